// ---- rrse_defs.vh ----
// constants for the return, rotate and subtract execution block
`ifndef RRSE_DEFS_VH
`define RRSE_DEFS_VH
// register offsets (byte addresses)
`define RRSE_OFS_CTRL      8'h00
`define RRSE_OFS_INSTR     8'h04
`define RRSE_OFS_WREG      8'h08
`define RRSE_OFS_STATUS    8'h0C
`define RRSE_OFS_BANK      8'h10
`define RRSE_OFS_SHADOW    8'h14
`define RRSE_OFS_PC        8'h18
`define RRSE_OFS_STACK     8'h1C
`define RRSE_OFS_RESULT    8'h20
// opcode patterns
`define RRSE_RET_HI        15'h0009
`define RRSE_ROT_HI        6'h0D
`define RRSE_SUBF_HI       6'h17
`define RRSE_SUBL_HI       8'h08
// opcode field positions
`define RRSE_BIT_D         9
`define RRSE_BIT_A         8
`define RRSE_BIT_S         0
// status flag positions
`define RRSE_FLG_C         0
`define RRSE_FLG_DC        1
`define RRSE_FLG_Z         2
`define RRSE_FLG_OV        3
`define RRSE_FLG_N         4
// operand limits
`define RRSE_IDX_LIMIT     8'h5F
`define RRSE_ACCESS_BANK   4'h0
`define RRSE_STACK_DEPTH   5'h1F
`define RRSE_SP_W          5
// ctrl bits
`define RRSE_CTL_EXT       0
`define RRSE_CTL_GO        1
`endif

// ---- rrse_core.v ----
// execution unit for subroutine return, rotate-left-carry and two subtracts
`include "rrse_defs.vh"

// How it works
// - return pops stack top into PC
// - s=1 restores working, flags, bank shadows
// - return keeps latches unchanged, and flags too when s=0
// - rotate left through carry, sets C N Z
// - rotate d selects working or file
// - access bit picks access or selected bank
// - extended set, a=0, f<=95 indexed offset
// - literal minus working into working, five flags
// - file minus working, two's complement, five flags
// - subtract d selects working or file
module rrse_core (
	// clock and reset
	input  wire        hclk,
	input  wire        hresetn,
	// ahb-lite slave
	input  wire        hsel,
	input  wire [7:0]  haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire        hready,
	input  wire [31:0] hwdata,
	output reg  [31:0] hrdata,
	output wire        hreadyout,
	output wire        hresp,
	// file register operand from data memory
	input  wire [7:0]  file_rdata,
	// data memory write-back and operand address
	output reg         file_we,
	output reg  [11:0] file_addr,
	output reg  [7:0]  file_wdata,
	output reg         file_indexed,
	// program counter and latches
	output reg  [20:0] pc_out,
	output reg  [7:0]  pc_upper_latch,
	output reg  [7:0]  pc_high_latch
);

	// architectural state
	reg [7:0]  wreg_r;
	reg [7:0]  status_r;
	reg [3:0]  bank_select_pointer;
	reg [7:0]  working_shadow;
	reg [7:0]  flags_shadow;
	reg [3:0]  bank_pointer_shadow;
	reg [15:0] instr_r;
	reg        ext_en_r;
	reg [`RRSE_SP_W-1:0] sp_r;
	reg [20:0] stack_mem [0:`RRSE_STACK_DEPTH-1];
	reg [7:0]  result_r;
	reg        go_r;

	// bus address phase capture
	// write data trails its address by a cycle, so the address is held
	reg        wr_pend_r;
	reg [7:0]  wr_addr_r;
	wire       ahb_act;
	assign ahb_act   = hsel & hready & htrans[1];
	// every register answers at once, so the bus never stalls
	assign hreadyout = 1'b1; // zero wait states
	assign hresp     = 1'b0; // always okay

	// decode of the held instruction
	// purely combinational off the opcode register; a freshly written
	// opcode needs one cycle before the operand address follows it
	wire       is_ret;
	wire       is_rot;
	wire       is_subf;
	wire       is_subl;
	wire       d_bit;
	wire       a_bit;
	wire       s_bit;
	wire [7:0] f_fld;
	wire [7:0] lit;
	assign is_ret  = (instr_r[15:1] == `RRSE_RET_HI);
	assign is_rot  = (instr_r[15:10] == `RRSE_ROT_HI);
	assign is_subf = (instr_r[15:10] == `RRSE_SUBF_HI);
	assign is_subl = (instr_r[15:8] == `RRSE_SUBL_HI);
	assign d_bit   = instr_r[`RRSE_BIT_D];
	assign a_bit   = instr_r[`RRSE_BIT_A];
	assign s_bit   = instr_r[`RRSE_BIT_S]; // shadow select of the return
	assign f_fld   = instr_r[7:0];
	assign lit     = instr_r[7:0];

	// operand address: access bank, selected bank or indexed offset
	// the indexed flag only marks the operand; the offset add sits outside
	reg [11:0] addr_c;
	reg        idx_c;
	always @* begin
		idx_c  = 1'b0;
		addr_c = {bank_select_pointer, f_fld};
		if (!a_bit) begin
			addr_c = {`RRSE_ACCESS_BANK, f_fld};
			if (ext_en_r && f_fld <= `RRSE_IDX_LIMIT)
				idx_c = 1'b1;
		end
	end

	// arithmetic: minuend minus working register
	// literal and file operand share one subtractor; one extra bit on
	// each operand makes the top bit of the difference the borrow out
	wire [7:0] minuend;
	wire [8:0] diff;
	wire [4:0] dnib;
	wire [7:0] dres;
	wire       sub_ov;
	assign minuend = is_subl ? lit : file_rdata;
	assign diff    = {1'b0, minuend} - {1'b0, wreg_r};
	assign dnib    = {1'b0, minuend[3:0]} - {1'b0, wreg_r[3:0]};
	assign dres    = diff[7:0];
	assign sub_ov  = (minuend[7] ^ wreg_r[7]) & (minuend[7] ^ dres[7]);

	// rotate left through carry
	// carry into bit 0 is the flag as it stood before this instruction
	wire [7:0] rres;
	assign rres = {file_rdata[6:0], status_r[`RRSE_FLG_C]};

	// subtract flags: carry and digit carry are inverted borrows
	// low nibble borrow drives the digit carry the same way as the carry
	reg [7:0] sub_flags;
	always @* begin
		sub_flags = status_r;
		sub_flags[`RRSE_FLG_C]  = ~diff[8];
		sub_flags[`RRSE_FLG_DC] = ~dnib[4];
		sub_flags[`RRSE_FLG_Z]  = (dres == 8'h00);
		sub_flags[`RRSE_FLG_OV] = sub_ov;
		sub_flags[`RRSE_FLG_N]  = dres[7];
	end

	// rotate flags, overflow and digit carry untouched
	// zero and negative are judged on the rotated value, not the operand
	reg [7:0] rot_flags;
	always @* begin
		rot_flags = status_r;
		rot_flags[`RRSE_FLG_C] = file_rdata[7];
		rot_flags[`RRSE_FLG_Z] = (rres == 8'h00);
		rot_flags[`RRSE_FLG_N] = rres[7];
	end

	// return stack bookkeeping: a push to a full stack and a pop from an
	// empty one are both dropped, so the pointer can never wrap
	wire                  stack_full;
	wire                  stack_empty;
	wire                  push_c;
	wire [`RRSE_SP_W-1:0] sp_dec;
	wire [`RRSE_SP_W-1:0] sp_inc;
	assign stack_full  = (sp_r == `RRSE_STACK_DEPTH);
	assign stack_empty = (sp_r == {`RRSE_SP_W{1'b0}});
	assign push_c      = wr_pend_r & (wr_addr_r == `RRSE_OFS_STACK) & ~stack_full;
	assign sp_dec      = sp_r - {{(`RRSE_SP_W-1){1'b0}}, 1'b1};
	assign sp_inc      = sp_r + {{(`RRSE_SP_W-1){1'b0}}, 1'b1};

	// bus writes, then instruction execution on go
	// file_we is a single-cycle strobe, cleared by default every cycle
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r           <= 1'b0;
			wr_addr_r           <= 8'h00;
			wreg_r              <= 8'h00;
			status_r            <= 8'h00;
			bank_select_pointer <= 4'h0;
			working_shadow      <= 8'h00;
			flags_shadow        <= 8'h00;
			bank_pointer_shadow <= 4'h0;
			instr_r             <= 16'h0000;
			ext_en_r            <= 1'b0;
			sp_r                <= {`RRSE_SP_W{1'b0}};
			result_r            <= 8'h00;
			go_r                <= 1'b0;
			pc_out              <= 21'h000000;
			pc_upper_latch      <= 8'h00;
			pc_high_latch       <= 8'h00;
			file_we             <= 1'b0;
			file_wdata          <= 8'h00;
		end else begin
			wr_pend_r <= ahb_act & hwrite;
			if (ahb_act)
				wr_addr_r <= haddr;
			file_we <= 1'b0;
			go_r    <= 1'b0;
			if (wr_pend_r) begin
				if (wr_addr_r == `RRSE_OFS_CTRL) begin
					ext_en_r <= hwdata[`RRSE_CTL_EXT];
					go_r     <= hwdata[`RRSE_CTL_GO];
				end else if (wr_addr_r == `RRSE_OFS_INSTR) begin
					instr_r <= hwdata[15:0];
				end else if (wr_addr_r == `RRSE_OFS_WREG) begin
					wreg_r <= hwdata[7:0];
				end else if (wr_addr_r == `RRSE_OFS_STATUS) begin
					status_r <= hwdata[7:0];
				end else if (wr_addr_r == `RRSE_OFS_BANK) begin
					bank_select_pointer <= hwdata[3:0];
				end else if (wr_addr_r == `RRSE_OFS_SHADOW) begin
					working_shadow      <= hwdata[7:0];
					flags_shadow        <= hwdata[15:8];
					bank_pointer_shadow <= hwdata[19:16];
				end else if (wr_addr_r == `RRSE_OFS_PC) begin
					pc_upper_latch <= hwdata[7:0];
					pc_high_latch  <= hwdata[15:8];
				end else if (wr_addr_r == `RRSE_OFS_STACK) begin
					// push: software loads return addresses
					if (!stack_full)
						sp_r <= sp_inc;
				end
			end
			// execution follows the bus writes, so it wins a same-cycle clash
			if (go_r) begin
				if (is_ret) begin
					// empty stack: pc and pointer both stay
					if (!stack_empty) begin
						pc_out <= stack_mem[sp_dec];
						sp_r   <= sp_dec;
					end
					if (s_bit) begin
						wreg_r              <= working_shadow;
						status_r            <= flags_shadow;
						bank_select_pointer <= bank_pointer_shadow;
					end
					// s clear: working, flags and bank are left alone
					// the pc latches are never written by a return
				end else if (is_rot) begin
					status_r <= rot_flags;
					result_r <= rres;
					if (d_bit) begin
						file_we    <= 1'b1;
						file_wdata <= rres;
					end else begin
						wreg_r <= rres;
					end
				end else if (is_subl) begin
					status_r <= sub_flags;
					wreg_r   <= dres;
					result_r <= dres;
				end else if (is_subf) begin
					status_r <= sub_flags;
					result_r <= dres;
					if (d_bit) begin
						file_we    <= 1'b1;
						file_wdata <= dres;
					end else begin
						wreg_r <= dres;
					end
				end
			end
		end
	end

	// return stack storage, no reset needed
	// entries above the pointer are never read, so reset fan-out is saved
	always @(posedge hclk) begin
		if (push_c)
			stack_mem[sp_r] <= hwdata[20:0];
	end

	// operand address follows the decode every cycle
	// registered so data memory sees a clean address, at one cycle of lag
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			file_addr    <= 12'h000;
			file_indexed <= 1'b0;
		end else begin
			file_addr    <= addr_c;
			file_indexed <= idx_c;
		end
	end

	// composite read words, packed as software writes them
	wire [31:0] shadow_word;
	wire [31:0] pc_word;
	assign shadow_word = {12'h000, bank_pointer_shadow, flags_shadow, working_shadow};
	assign pc_word     = {11'h000, pc_out[4:0], pc_high_latch, pc_upper_latch};

	// read mux, address phase registered into data phase
	// data is chosen in the address phase and held through the data phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (ahb_act && !hwrite) begin
			if (haddr == `RRSE_OFS_CTRL)
				hrdata <= {31'h00000000, ext_en_r};
			else if (haddr == `RRSE_OFS_INSTR)
				hrdata <= {16'h0000, instr_r};
			else if (haddr == `RRSE_OFS_WREG)
				hrdata <= {24'h000000, wreg_r};
			else if (haddr == `RRSE_OFS_STATUS)
				hrdata <= {24'h000000, status_r};
			else if (haddr == `RRSE_OFS_BANK)
				hrdata <= {28'h0000000, bank_select_pointer};
			else if (haddr == `RRSE_OFS_SHADOW)
				hrdata <= shadow_word;
			else if (haddr == `RRSE_OFS_PC)
				hrdata <= pc_word;
			else if (haddr == `RRSE_OFS_STACK)
				hrdata <= {27'h0000000, sp_r};
			else if (haddr == `RRSE_OFS_RESULT)
				hrdata <= {24'h000000, result_r};
			else
				hrdata <= 32'h00000000; // unmapped reads zero
		end
	end

endmodule

// ---- rrse_properties.sv ----
// concurrent checks on the execution block's ports
module rrse_props (
	// clock and reset
	input wire        hclk,
	input wire        hresetn,
	// bus side
	input wire        hsel,
	input wire [7:0]  haddr,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire        hready,
	input wire [31:0] hwdata,
	// operand and results
	input wire [7:0]  file_rdata,
	input wire        file_we,
	input wire [11:0] file_addr,
	input wire [7:0]  file_wdata,
	input wire        file_indexed,
	input wire [20:0] pc_out,
	input wire [7:0]  pc_upper_latch,
	input wire [7:0]  pc_high_latch
);
	timeunit 1ns;
	timeprecision 1ns;
	logic        wph_r;
	logic [7:0]  wa_r;
	logic [15:0] ins_r;
	wire         rot = ins_r[15:10] == 6'h0D;
	wire         fop = rot || ins_r[15:10] == 6'h17;
	wire         ret = ins_r[15:1] == 15'h0009;
	// copy of the last opcode written, the only view of decode from outside
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wph_r <= 1'h0;
			wa_r  <= 8'h00;
			ins_r <= 16'h0000;
		end else if (hready) begin
			wph_r <= hsel && htrans[1] && hwrite;
			wa_r  <= haddr;
			if (wph_r && wa_r == 8'h04) ins_r <= hwdata[15:0];
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_pop; $changed(pc_out) |-> ret; endproperty
	a_pop: assert property (p_pop) else $error("pc moved outside a return");
	property p_latch; $changed({pc_upper_latch, pc_high_latch}) |-> $past(wph_r && wa_r == 8'h18); endproperty
	a_latch: assert property (p_latch) else $error("latch moved without bus write");
	property p_we; file_we |-> fop && ins_r[9]; endproperty
	a_we: assert property (p_we) else $error("write-back with d clear");
	property p_rot; file_we && rot |-> file_wdata[7:1] == file_rdata[6:0]; endproperty
	a_rot: assert property (p_rot) else $error("rotate shift wrong");
	// skip the cycle after an opcode write, when the operand address may lag
	property p_idx; $stable(ins_r) && file_indexed |-> !ins_r[8] && ins_r[7:0] <= 8'h5F; endproperty
	a_idx: assert property (p_idx) else $error("indexed flag out of range");
	property p_acc; $stable(ins_r) && fop && !ins_r[8] |-> file_addr == {4'h0, ins_r[7:0]}; endproperty
	a_acc: assert property (p_acc) else $error("access bank address wrong");
	property p_bsel; $stable(ins_r) && fop && ins_r[8] |-> file_addr[7:0] == ins_r[7:0]; endproperty
	a_bsel: assert property (p_bsel) else $error("banked address wrong");
	property p_pulse; file_we |=> !file_we; endproperty
	a_pulse: assert property (p_pulse) else $error("write-back held");
endmodule
bind rrse_core rrse_props u_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
	.hwdata, .file_rdata, .file_we, .file_addr, .file_wdata, .file_indexed, .pc_out,
	.pc_upper_latch, .pc_high_latch);

// ---- rrse_dmem.sv ----
// data memory model standing behind the operand port
module rrse_dmem (
	// clock
	input wire          hclk,
	// write-back and operand address
	input wire          file_we,
	input wire [11:0]   file_addr,
	input wire [7:0]    file_wdata,
	// operand read, combinational
	output logic [7:0]  file_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [0:4095];
	// cleared so an operand never reads as unknown
	initial foreach (mem[i]) mem[i] = 8'h00;
	assign file_rdata = mem[file_addr];
	// write lands at the edge that sees the strobe
	always @(posedge hclk) if (file_we) mem[file_addr] <= file_wdata;
endmodule

// ---- rrse_tb.sv ----
// self-checking bench for the return, rotate and subtract block
module return_rotate_subtract_exec_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        hclk = 1'h0;
	logic        hresetn = 1'h0;
	logic [7:0]  haddr = 8'h00;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'h0;
	logic [31:0] hwdata = 32'h0;
	wire  [31:0] hrdata;
	wire         hreadyout, hresp, file_we, file_indexed;
	wire  [7:0]  file_rdata, file_wdata, pc_upper_latch, pc_high_latch;
	wire  [11:0] file_addr;
	wire  [20:0] pc_out;
	logic [31:0] q;
	int          failures = 0;
	int          n_checks = 0;
	always #20 hclk = ~hclk;
	rrse_core u_dut (.hclk, .hresetn, .hsel(1'h1), .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .file_rdata, .file_we,
		.file_addr, .file_wdata, .file_indexed, .pc_out, .pc_upper_latch, .pc_high_latch);
	rrse_dmem u_mem (.hclk, .file_we, .file_addr, .file_wdata, .file_rdata);
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// one single transfer; entered just after a rising edge
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'h1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'h1) @(posedge hclk);
		q = hrdata;
	endtask
	task rchk(input logic [7:0] a, input logic [31:0] e);
		xfer(1'h0, a, 32'h0);
		chk(q, e);
	endtask
	// load opcode, fire go, allow the three cycles the walk gives
	task run(input logic [15:0] op, input logic ext);
		xfer(1'h1, 8'h04, {16'h0, op});
		xfer(1'h1, 8'h00, {30'h0, 1'h1, ext});
		repeat (3) @(posedge hclk);
	endtask
	// expected N OV Z DC C of a minus b, carry as inverted borrow
	function automatic logic [7:0] sflg(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] r;
		r = a - b;
		return {3'h0, r[7], (a[7] ^ b[7]) & (a[7] ^ r[7]), r == 8'h00, a[3:0] >= b[3:0], a >= b};
	endfunction
	task t_sublit;
		logic [7:0] w [4];
		w = '{8'h01, 8'h02, 8'h03, 8'h80};
		foreach (w[i]) begin
			xfer(1'h1, 8'h0C, 32'h0);
			xfer(1'h1, 8'h08, {24'h0, w[i]});
			run(16'h0802, 1'h0);
			rchk(8'h08, {24'h0, 8'(8'h02 - w[i])});
			rchk(8'h0C, {24'h0, sflg(8'h02, w[i])});
		end
	endtask
	task t_subreg;
		u_mem.mem[12'h020] = 8'h03;
		xfer(1'h1, 8'h08, 32'h2);
		run(16'h5E20, 1'h0);
		chk({24'h0, u_mem.mem[12'h020]}, 32'h1);
		rchk(8'h08, 32'h2);
		run(16'h5C20, 1'h0);
		rchk(8'h08, 32'hFF);
		rchk(8'h0C, {24'h0, sflg(8'h01, 8'h02)});
	endtask
	// banked operand; digit carry and overflow must survive the rotate
	task t_rot;
		u_mem.mem[12'h340] = 8'h81;
		xfer(1'h1, 8'h10, 32'h3);
		xfer(1'h1, 8'h0C, 32'h0B);
		run(16'h3540, 1'h0);
		rchk(8'h08, 32'h03);
		chk({20'h0, file_addr}, 32'h340);
		rchk(8'h0C, 32'h0B);
		u_mem.mem[12'h340] = 8'h40;
		run(16'h3740, 1'h0);
		chk({24'h0, u_mem.mem[12'h340]}, 32'h81);
		rchk(8'h0C, 32'h1A);
	endtask
	task t_idx;
		xfer(1'h1, 8'h00, 32'h1);
		run(16'h5C5F, 1'h1);
		chk({31'h0, file_indexed}, 32'h1);
		chk({20'h0, file_addr}, 32'h05F);
		run(16'h5C60, 1'h1);
		chk({31'h0, file_indexed}, 32'h0);
	endtask
	task t_ret;
		xfer(1'h1, 8'h18, 32'hABCD);
		xfer(1'h1, 8'h14, 32'h51177);
		xfer(1'h1, 8'h1C, 32'h1234);
		xfer(1'h1, 8'h1C, 32'h0456);
		xfer(1'h1, 8'h08, 32'h22);
		xfer(1'h1, 8'h0C, 32'h05);
		xfer(1'h1, 8'h10, 32'h2);
		run(16'h0012, 1'h0);
		chk({11'h0, pc_out}, 32'h0456);
		rchk(8'h08, 32'h22);
		rchk(8'h0C, 32'h05);
		rchk(8'h10, 32'h2);
		run(16'h0013, 1'h0);
		chk({11'h0, pc_out}, 32'h1234);
		chk({16'h0, pc_high_latch, pc_upper_latch}, 32'hABCD);
		rchk(8'h08, 32'h77);
		rchk(8'h0C, 32'h11);
		rchk(8'h10, 32'h5);
		rchk(8'h3C, 32'h0);
		chk({31'h0, hresp}, 32'h0);
	endtask
	task report_and_stop;
		$display("checks=%0d failures=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		t_sublit();
		t_subreg();
		t_rot();
		t_idx();
		t_ret();
		report_and_stop();
	end
	// whole run is under two hundred cycles; this cuts a stuck handshake
	initial begin
		repeat (20000) @(posedge hclk);
		failures++;
		report_and_stop();
	end
endmodule
